/* bench/otc_ext_osc_model.sv */
// Purpose: external clock source seen by the backup detector
// Assumes: derived from the bench clock, edges aligned to the bus clock
// Notes:   stands still low when stopped, which models a halted crystal
`timescale 1ns/100ps
`default_nettype none
module otc_ext_osc_model #(
    parameter int HALF = 2
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      ext_clk_o
);
    int   cnt_ff;
    logic clk_ff;

    // no free run: a stopped source must look dead to the detector
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_ff <= 0;
            clk_ff <= 1'b0;
        end else if (cnt_ff == HALF - 1) begin
            cnt_ff <= 0;
            clk_ff <= ~clk_ff;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end

    assign ext_clk_o = clk_ff;
endmodule
`default_nettype wire

/* bench/otc_top_tb_top.sv */
// Purpose: self-checking bench for the trim and clock backup block
// Assumes: classic Wishbone master, short halt limit
// Notes:   expectations come from the bit layout, never from reads
`timescale 1ns/100ps
`default_nettype none
module otc_top_tb_top import otc_pkg::*; ;
    localparam int HL = 16;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [7:0]        wb_adr_i = 8'h00;
    logic [3:0]        wb_sel_i = 4'hF;
    logic [31:0]       wb_dat_i = 32'h0;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic [7:0]        flash_trim_i = 8'h5A;
    logic              osc_freq_select_i = 1'b0;
    logic              ext_clk_i;
    logic              ext_run = 1'b0;
    logic signed [7:0] osc_trim_o;
    logic              trim_active_o;
    logic              sys_clk_source_sel_o;
    logic              clock_output_pin_o;
    logic              xtal_out_pin_o;
    logic              xtal_in_pin_o;
    logic              irq_o;
    logic [31:0]       rd;
    int                bad_count = 0;
    int                samples_checked = 0;

    always #4 clk_i = ~clk_i;

    otc_top #(.HALT_LIMIT(HL)) u_otc_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .flash_trim_i(flash_trim_i),
        .osc_freq_select_i(osc_freq_select_i), .ext_clk_i(ext_clk_i),
        .osc_trim_o(osc_trim_o), .trim_active_o(trim_active_o),
        .sys_clk_source_sel_o(sys_clk_source_sel_o),
        .clock_output_pin_o(clock_output_pin_o),
        .xtal_out_pin_o(xtal_out_pin_o), .xtal_in_pin_o(xtal_in_pin_o),
        .irq_o(irq_o));

    otc_ext_osc_model #(.HALF(2)) u_otc_ext_osc_model (
        .clk_i(clk_i), .run_i(ext_run), .ext_clk_o(ext_clk_i));

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // request held until ack is seen at a rising edge
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("[ERR] %0t no bus answer", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wb_w(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, rd);
    endtask

    task automatic wb_rc(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0, rd);
        chk32(rd, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    initial begin
        idle(4);
        chk32({24'h0, osc_trim_o}, 32'h0);
        idle(12);
        rst_i <= 1'b0;
        wb_rc(ADR_TRIM, 32'h5A);
        wb_w(ADR_TRIM, 32'h11);
        wb_rc(ADR_TRIM, 32'h5A);
        wb_w(ADR_PROT, 32'h1 << PR_WE);
        wb_w(ADR_TRIM, 32'h80);
        chk32({24'h0, osc_trim_o}, 32'h80);
        chk1(osc_trim_o < 8'sh00, 1'b1);
        wb_w(ADR_TRIM, 32'h7F);
        chk1(osc_trim_o > 8'sh00, 1'b1);
        wb_w(ADR_PROT, (32'h1 << PR_LOCK) | (32'h1 << PR_WE));
        wb_w(ADR_TRIM, 32'h01);
        wb_rc(ADR_TRIM, 32'h7F);
        wb_w(ADR_PROT, 32'h1 << PR_WE);
        wb_w(ADR_TRIM, 32'h01);
        wb_rc(ADR_TRIM, 32'h7F);
        osc_freq_select_i <= 1'b1;
        idle(2);
        chk1(trim_active_o, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wb_w(ADR_CLOCK_CTRL_STATUS, 32'(i) << CK_PIN_LO);
            idle(2);
            chk1(clock_output_pin_o, i == 2);
            chk1(xtal_out_pin_o, i == 3);
            chk1(xtal_in_pin_o, i[0]);
        end
        wb_rc(8'h14, 32'h0);
        // backup off: a dead source must not move the clock
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h10);
        idle(HL + 8);
        chk1(sys_clk_source_sel_o, 1'b1);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h13);
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h00);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h06);
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h00);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h02);
        wb_xfer(1'b0, ADR_ISTAT, 32'h0, rd);
        // backup on first: a stale halt flag would force a fallback
        ext_run <= 1'b1;
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h20);
        idle(20);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h20);
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h30);
        idle(4);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h31);
        ext_run <= 1'b0;
        idle(HL + 12);
        chk1(sys_clk_source_sel_o, 1'b0);
        chk1(irq_o, 1'b0);
        wb_rc(ADR_CLOCK_CTRL_STATUS, 32'h26);
        wb_w(ADR_IMASK, 32'h3);
        idle(2);
        chk1(irq_o, 1'b1);
        wb_rc(ADR_ISTAT, 32'h3);
        idle(2);
        chk1(irq_o, 1'b0);
        wb_rc(ADR_ISTAT, 32'h0);
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h2C);
        idle(2);
        chk1(irq_o, 1'b1);
        wb_w(ADR_CLOCK_CTRL_STATUS, 32'h28);
        idle(2);
        chk1(irq_o, 1'b0);
        final_report;
    end

    initial begin
        idle(5000);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end
endmodule
`default_nettype wire

/* rtl/otc_pkg.sv */
// Purpose: shared constants for the oscillator trim and clock backup block
// Assumes: 32-bit classic Wishbone, byte addressed, one word per register
// Notes:   offsets, field positions and reset values live here only
package otc_pkg;
    localparam int          ADR_W        = 8;
    localparam logic [7:0]  ADR_TRIM     = 8'h00;
    localparam logic [7:0]  ADR_CLOCK_CTRL_STATUS    = 8'h04;
    localparam logic [7:0]  ADR_PROT     = 8'h08;
    localparam logic [7:0]  ADR_ISTAT    = 8'h0C;
    localparam logic [7:0]  ADR_IMASK    = 8'h10;

    // clock_ctrl_status field positions
    localparam int          CK_PIN_HI    = 7;
    localparam int          CK_PIN_LO    = 6;
    localparam int          CK_BAKE      = 5;
    localparam int          CK_SEL       = 4;
    localparam int          CK_IE        = 3;
    localparam int          CK_IF        = 2;
    localparam int          CK_HLT       = 1;
    localparam int          CK_STA       = 0;

    // trim protect field positions
    localparam int          PR_LOCK      = 5;
    localparam int          PR_WE        = 4;

    // interrupt status / mask field positions
    localparam int          IRQ_SWITCH   = 0;
    localparam int          IRQ_HALT     = 1;
    localparam int          IRQ_W        = 2;

    localparam logic [7:0]  TRIM_RESET   = 8'h00;
    localparam logic [1:0]  PIN_RESET    = 2'h0;
    localparam logic [1:0]  PIN_IO_IO    = 2'h0;
    localparam logic [1:0]  PIN_CLOCK_OUTPUT_PIN   = 2'h2;
    localparam logic [1:0]  PIN_EXTCLK   = 2'h1;
    localparam logic [1:0]  PIN_XTAL     = 2'h3;
    localparam int          HALT_CYCLES  = 64;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } otc_state_t;
endpackage

/* rtl/otc_top.sv */
// Purpose: oscillator trim register, clock source select, ext clock backup
// Assumes: clk_i is the on-chip oscillator clock, ext_clk_i an async pin
// Notes:   halt detector counts clk_i cycles between external edges
//
// What this block does
// - trim applies only to the 20 MHz setting
// - trim loads from flash right after reset
// - reset clears trim to zero first
// - trim writes change frequency immediately
// - trim is signed, top bit is sign
// - two select bits map port C pins
// - halt detector runs only while backup enabled
// - halt forces system clock to on-chip oscillator
// - halt detector runs on on-chip oscillator clock
// - trim writable only when enabled, unlocked
// - switch to on-chip sets flag; read-then-write-0 clears
// - halt flag: 0 running, 1 halted or disabled
// - status bit: 0 on-chip, 1 external clock
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module otc_top
    import otc_pkg::*;
#(
    parameter int HALT_LIMIT = HALT_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [7:0]        flash_trim_i,
    input  wire logic              osc_freq_select_i,
    input  wire logic              ext_clk_i,
    output logic signed [7:0]      osc_trim_o,
    output logic                   trim_active_o,
    output logic                   sys_clk_source_sel_o,
    output logic                   clock_output_pin_o,
    output logic                   xtal_out_pin_o,
    output logic                   xtal_in_pin_o,
    output logic                   irq_o
);
    localparam int CNT_W = $clog2(HALT_LIMIT + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(HALT_LIMIT);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    otc_state_t        state_ff;
    logic [7:0]        trim_ff;
    logic              trim_act_ff;
    logic [1:0]        pin_sel_ff;
    logic              clock_output_pin_ff;
    logic              xout_ff;
    logic              xin_ff;
    logic              bake_ff;
    logic              sel_ff;
    logic              ie_ff;
    logic              if_ff;
    logic              if_seen_ff;
    logic              lock_ff;
    logic              twe_ff;
    logic [IRQ_W-1:0]  istat_ff;
    logic [IRQ_W-1:0]  imask_ff;
    logic              irq_ff;
    logic              ack_ff;
    logic [31:0]       rdat_ff;
    logic              ext_s1_ff;
    logic              ext_s2_ff;
    logic              ext_s3_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              halt_ff;

    logic              req;
    logic              wr;
    logic              rd;
    logic              wr_trim;
    logic              wr_ck;
    logic              wr_prot;
    logic              wr_imask;
    logic              rd_ck;
    logic              rd_istat;
    logic              trim_ok;
    logic              ext_edge;
    logic              nxt_sel;
    logic              sw_evt;
    logic              halt_evt;
    logic              nxt_if;
    logic [7:0]        ck_rd;
    logic [31:0]       nxt_rdat;

    function automatic logic hit(input logic [ADR_W-1:0] a,
                                 input logic [7:0] off);
        return a == off[ADR_W-1:0];
    endfunction

    // bus requests wait out the flash load cycle
    assign req      = wb_cyc_i & wb_stb_i & ~ack_ff & (state_ff == ST_RUN);
    assign wr       = req & wb_we_i & wb_sel_i[0];
    assign rd       = req & ~wb_we_i;
    assign wr_trim  = wr & hit(wb_adr_i, ADR_TRIM);
    assign wr_ck    = wr & hit(wb_adr_i, ADR_CLOCK_CTRL_STATUS);
    assign wr_prot  = wr & hit(wb_adr_i, ADR_PROT);
    assign wr_imask = wr & hit(wb_adr_i, ADR_IMASK);
    assign rd_ck    = rd & hit(wb_adr_i, ADR_CLOCK_CTRL_STATUS);
    assign rd_istat = rd & hit(wb_adr_i, ADR_ISTAT);
    assign trim_ok  = twe_ff & ~lock_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_LOAD;
        end else begin
            state_ff <= ST_RUN;
        end
    end

    // trim is live on the oscillator the cycle after the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_ff <= TRIM_RESET;
        end else if (state_ff == ST_LOAD) begin
            trim_ff <= flash_trim_i;
        end else if (wr_trim && trim_ok) begin
            trim_ff <= wb_dat_i[7:0];
        end
    end
    assign osc_trim_o = $signed(trim_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_act_ff <= 1'b0;
        end else begin
            trim_act_ff <= osc_freq_select_i;
        end
    end
    assign trim_active_o = trim_act_ff;

    // lock is sticky until reset, clearing writes are ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_ff <= 1'b0;
            twe_ff  <= 1'b0;
        end else if (wr_prot) begin
            lock_ff <= lock_ff | wb_dat_i[PR_LOCK];
            twe_ff  <= wb_dat_i[PR_WE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sel_ff <= PIN_RESET;
            bake_ff    <= 1'b0;
            ie_ff      <= 1'b0;
        end else if (wr_ck) begin
            pin_sel_ff <= {wb_dat_i[CK_PIN_HI], wb_dat_i[CK_PIN_LO]};
            bake_ff    <= wb_dat_i[CK_BAKE];
            ie_ff      <= wb_dat_i[CK_IE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_output_pin_ff <= 1'b0;
            xout_ff   <= 1'b0;
            xin_ff    <= 1'b0;
        end else begin
            clock_output_pin_ff <= (pin_sel_ff == PIN_CLOCK_OUTPUT_PIN);
            xout_ff   <= (pin_sel_ff == PIN_XTAL);
            xin_ff    <= pin_sel_ff[0];
        end
    end
    assign clock_output_pin_o = clock_output_pin_ff;
    assign xtal_out_pin_o     = xout_ff;
    assign xtal_in_pin_o      = xin_ff;

    // runs on clk_i; stopping the on-chip oscillator blinds it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clk_i;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end
    assign ext_edge = ext_s2_ff & ~ext_s3_ff;

    // external clock must rise faster than HALT_LIMIT clk_i cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !bake_ff) begin
            cnt_ff  <= CNT_ZERO;
            halt_ff <= 1'b1;
        end else if (ext_edge) begin
            cnt_ff  <= CNT_ZERO;
            halt_ff <= 1'b0;
        end else if (cnt_ff != CNT_MAX) begin
            cnt_ff  <= cnt_ff + CNT_W'(1);
            halt_ff <= (cnt_ff + CNT_W'(1) == CNT_MAX);
        end
    end
    assign halt_evt = bake_ff & ~ext_edge & ~halt_ff
                    & (cnt_ff + CNT_W'(1) == CNT_MAX);

    always_comb begin
        nxt_sel = sel_ff;
        if (wr_ck) begin
            if (!bake_ff || !wb_dat_i[CK_SEL] || !if_ff) begin
                nxt_sel = wb_dat_i[CK_SEL];
            end
        end
        if (bake_ff && halt_ff && sel_ff) begin
            nxt_sel = 1'b0;
        end
    end
    assign sw_evt = sel_ff & ~nxt_sel;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end
    assign sys_clk_source_sel_o = sel_ff;

    // a new switch beats a clearing write in the same cycle
    always_comb begin
        nxt_if = if_ff;
        if (wr_ck && !wb_dat_i[CK_IF] && if_seen_ff) begin
            nxt_if = 1'b0;
        end
        if (sw_evt) begin
            nxt_if = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if_ff      <= 1'b0;
            if_seen_ff <= 1'b0;
        end else begin
            if_ff <= nxt_if;
            if (rd_ck && if_ff) begin
                if_seen_ff <= 1'b1;
            end else if (!nxt_if) begin
                if_seen_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_ff <= '0;
        end else begin
            istat_ff[IRQ_SWITCH] <= sw_evt
                                  | (istat_ff[IRQ_SWITCH] & ~rd_istat);
            istat_ff[IRQ_HALT]   <= halt_evt
                                  | (istat_ff[IRQ_HALT] & ~rd_istat);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imask_ff <= '0;
        end else if (wr_imask) begin
            imask_ff <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // switch flag also reaches the line through its own enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (|(istat_ff & imask_ff)) | (if_ff & ie_ff);
        end
    end
    assign irq_o = irq_ff;

    always_comb begin
        ck_rd = {pin_sel_ff, bake_ff, sel_ff, ie_ff, if_ff,
                 halt_ff, sel_ff};
        nxt_rdat = '0;
        if (hit(wb_adr_i, ADR_TRIM)) begin
            nxt_rdat[7:0] = trim_ff;
        end else if (hit(wb_adr_i, ADR_CLOCK_CTRL_STATUS)) begin
            nxt_rdat[7:0] = ck_rd;
        end else if (hit(wb_adr_i, ADR_PROT)) begin
            nxt_rdat[PR_LOCK] = lock_ff;
            nxt_rdat[PR_WE]   = twe_ff;
        end else if (hit(wb_adr_i, ADR_ISTAT)) begin
            nxt_rdat[IRQ_W-1:0] = istat_ff;
        end else if (hit(wb_adr_i, ADR_IMASK)) begin
            nxt_rdat[IRQ_W-1:0] = imask_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff <= req;
            if (rd) begin
                rdat_ff <= nxt_rdat;
            end
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    sequence s_switch;
        sel_ff ##1 !sel_ff;
    endsequence
    sequence s_flag_up;
        if_ff && istat_ff[IRQ_SWITCH];
    endsequence

    AST_TRIM_RESET: assert property (@(posedge clk_i)
        $past(rst_i) && (state_ff == ST_LOAD) |-> trim_ff == TRIM_RESET)
        else $error("trim not cleared by reset");
    AST_TRIM_LOAD: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_ff == ST_LOAD |=> trim_ff == $past(flash_trim_i))
        else $error("flash trim not loaded");
    AST_TRIM_WRITE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_trim && twe_ff && !lock_ff |=> osc_trim_o == $past(wb_dat_i[7:0]))
        else $error("trim write not applied");
    AST_TRIM_BLOCK: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_trim && (lock_ff || !twe_ff) && state_ff == ST_RUN
        |=> $stable(trim_ff))
        else $error("protected trim written");
    AST_PIN_MAP: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pin_sel_ff == PIN_EXTCLK ##1 pin_sel_ff == PIN_EXTCLK
        |-> xin_ff && !xout_ff && !clock_output_pin_ff)
        else $error("pin map wrong");
    AST_HALT_OFF: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !bake_ff |=> cnt_ff == CNT_ZERO && halt_ff)
        else $error("detector active while backup off");
    AST_FORCE_SW: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bake_ff && halt_ff && sel_ff |=> !sel_ff)
        else $error("no fallback on halt");
    // flag and status rise on the same edge that drops the select
    AST_IRQ_SET: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_switch |-> s_flag_up)
        else $error("switch flag not set");
    // select falls one cycle after the halt flag, not with it
    AST_HALT_DET: assert property (@(posedge clk_i)
        disable iff (rst_i)
        halt_evt |=> halt_ff ##1 !sel_ff)
        else $error("halt not declared");
    AST_ACK_PULSE: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule
`default_nettype wire
